// ==== dxi_ext_irq.sv ====
// Purpose: external interrupt logic of a four-group digital I/O block
// Assumes: plain register port, read data one cycle after the strobe
// Notes:   group 3 port C bits 7/6 act as enable and request in interrupt mode
//
// What this block does
// - config switches two group-3 lines to interrupt
// - enable input active low, permits requests
// - request is edge sensitive, not level
// - each group may latch data on request
// - trigger on rising, falling or both edges
// - rising edge is the reset default
// - both-edge mode gives one request per edge
// - falling edge during pending service is ignored
// - edges ignored while pending flag is set
// - first ignored edge sets missed flag once
//
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/100ps
`include "dxi_defines.svh"
module dxi_ext_irq
  import dxi_pkg::*;
(
  input  wire logic                                 clk,      // 10 MHz board clock
  input  wire logic                                 resetn,   // async reset, active low
  input  wire logic [`DXI_ADDR_W-1:0]               addr,     // register byte address
  input  wire logic [`DXI_DATA_W-1:0]               wrData,   // write data
  input  wire logic                                 wrStb,    // write strobe
  input  wire logic                                 rdStb,    // read strobe
  input  wire logic [`DXI_GROUPS*`DXI_GROUP_W-1:0]  groupIn,  // input data of all groups
  output logic      [`DXI_DATA_W-1:0]               rdData,   // read data, cycle after rdStb
  output logic                                      irqOut    // level interrupt
);

  dxi_state_t q;  // registered state
  dxi_state_t d;  // next state

  logic reqRise;  // synchronised rising edge
  logic reqFall;  // synchronised falling edge
  logic enNSync;  // synchronised enable, active low

  // request and enable lines of group 3 port C
  dxi_sync_edge uSync (
    .clk     (clk),
    .resetn  (resetn),
    .reqIn   (groupIn[`DXI_REQ_GROUP*`DXI_GROUP_W+`DXI_REQ_BIT]),
    .enNIn   (groupIn[`DXI_REQ_GROUP*`DXI_GROUP_W+`DXI_ENN_BIT]),
    .reqRise (reqRise),
    .reqFall (reqFall),
    .enNSync (enNSync)
  );

  // true when the address hits a given register offset
  function automatic logic hit(input logic [`DXI_ADDR_W-1:0] a,
                               input logic [`DXI_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  // true when the address falls in the latched-data window
  function automatic logic inLatch(input logic [`DXI_ADDR_W-1:0] a);
    inLatch = (a >= `DXI_OFF_LATCH0) && (a <= `DXI_OFF_LATCH3) && (a[1:0] == 2'h0);
  endfunction

  // qualified trigger terms
  logic selRise;   // rising edges selected
  logic selFall;   // falling edges selected
  logic trig;      // a selected, enabled edge
  logic accept;    // edge taken as a new request
  logic ignored;   // edge dropped while pending
  logic [`DXI_ST_W-1:0] clr;  // bits cleared by software

  // edge selection and enable qualification
  always_comb begin
    selRise = (q.edgeSel != `DXI_EDGE_FALL);
    selFall = (q.edgeSel != `DXI_EDGE_RISE);
    trig    = q.mode && !enNSync &&
              ((reqRise && selRise) || (reqFall && selFall));
    accept  = trig && !q.status[`DXI_ST_PEND];
    ignored = trig && q.status[`DXI_ST_PEND];
    clr     = (wrStb && hit(addr, `DXI_OFF_CLEAR)) ? wrData[`DXI_ST_W-1:0] : '0;
  end

  // next-state logic: registers, flags, latches, read answer
  always_comb begin
    logic [`DXI_ST_W-1:0] setBits;  // bits set by hardware this cycle
    logic [2:0]           gIdx;     // latch group index for reads
    setBits = '0;
    gIdx    = '0;
    d       = q;
    d.rdData = '0;
    // software writes to configuration
    if (wrStb) begin
      if (hit(addr, `DXI_OFF_CTRL)) begin
        d.mode    = wrData[`DXI_CTRL_MODE];
        d.edgeSel = wrData[`DXI_CTRL_EDGE +: 2];
        d.latchEn = wrData[`DXI_CTRL_LATCH +: `DXI_GROUPS];
      end
      if (hit(addr, `DXI_OFF_IRQEN)) begin
        d.irqEn = wrData[`DXI_ST_W-1:0];
      end
    end
    // accepted edge: pending, edge record, data latch
    if (accept) begin
      setBits[`DXI_ST_PEND] = 1'b1;
      setBits[`DXI_ST_RISE] = reqRise;
      setBits[`DXI_ST_FALL] = reqFall;
      for (int g = 0; g < `DXI_GROUPS; g++) begin
        if (q.latchEn[g]) begin
          d.latch[g] = groupIn[g*`DXI_GROUP_W +: `DXI_GROUP_W];
        end
      end
    end
    // only the first ignored edge reports a miss
    if (ignored && !q.missSeen) begin
      setBits[`DXI_ST_MISS] = 1'b1;
    end
    // software clear, hardware set wins
    d.status   = (q.status & ~clr) | setBits;
    d.missSeen = (q.missSeen && !clr[`DXI_ST_PEND]) ||
                 (ignored && !q.missSeen);
    // level interrupt from enabled status bits
    d.irq = |(d.status & d.irqEn);
    // read decode, unmapped reads give zero
    if (rdStb) begin
      if (hit(addr, `DXI_OFF_CTRL)) begin
        d.rdData[`DXI_CTRL_MODE]              = q.mode;
        d.rdData[`DXI_CTRL_EDGE +: 2]         = q.edgeSel;
        d.rdData[`DXI_CTRL_LATCH +: `DXI_GROUPS] = q.latchEn;
      end else if (hit(addr, `DXI_OFF_STATUS)) begin
        d.rdData[`DXI_ST_W-1:0] = q.status;
      end else if (hit(addr, `DXI_OFF_IRQEN)) begin
        d.rdData[`DXI_ST_W-1:0] = q.irqEn;
      end else if (inLatch(addr)) begin
        gIdx = addr[4:2];
        d.rdData[`DXI_GROUP_W-1:0] = q.latch[gIdx[1:0]];
      end
    end
  end

  // state register; reset gives rising-edge mode, all flags clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q         <= '0;
      q.edgeSel <= `DXI_EDGE_RISE;
    end else begin
      q <= d;
    end
  end

  // outputs straight from flip-flops
  assign rdData = q.rdData;
  assign irqOut = q.irq;

  // ---------------- assertions ----------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  logic clrPend;  // software clears pending this cycle
  assign clrPend = clr[`DXI_ST_PEND];

  // selected rising edge with pins enabled raises pending and rise flag
  a_rise_sets_pend: assert property (
    (q.mode && !enNSync && reqRise && q.edgeSel == `DXI_EDGE_RISE
     && !q.status[`DXI_ST_PEND])
    |=> (q.status[`DXI_ST_PEND] && q.status[`DXI_ST_RISE]))
    else $error("selected rising edge did not raise pending");

  // falling-only mode never records a rise from an edge
  a_fall_only_mode: assert property (
    (q.edgeSel == `DXI_EDGE_FALL && !q.status[`DXI_ST_RISE])
    |=> !q.status[`DXI_ST_RISE])
    else $error("rise flag set in falling-only mode");

  // both-edge mode takes a falling edge as its own request
  a_both_fall_req: assert property (
    (q.mode && !enNSync && reqFall && q.edgeSel == `DXI_EDGE_BOTH
     && !q.status[`DXI_ST_PEND])
    |=> (q.status[`DXI_ST_PEND] && q.status[`DXI_ST_FALL]))
    else $error("falling edge lost in both-edge mode");

  // while pending, edges leave latched data alone
  a_pend_no_latch: assert property (
    (q.status[`DXI_ST_PEND] && (reqRise || reqFall)) |=> $stable(q.latch))
    else $error("latched data changed while pending");

  // first ignored edge sets the missed flag
  a_miss_first: assert property (
    (ignored && !q.missSeen) |=> (q.status[`DXI_ST_MISS] && q.missSeen))
    else $error("first ignored edge did not set missed");

  // a recorded miss keeps later ignored edges from setting missed again
  a_miss_once: assert property (
    (ignored && q.missSeen && !q.status[`DXI_ST_MISS] && !clrPend)
    |=> !q.status[`DXI_ST_MISS])
    else $error("missed set again by a later edge");

  // disabled enable pin keeps requests out
  a_enable_gate: assert property (
    ((enNSync || !q.mode) && !q.status[`DXI_ST_PEND]) |=> !q.status[`DXI_ST_PEND])
    else $error("request taken while disabled");

  // a pin change reaches the pending flag exactly three edges later, not before
  a_sync_latency: assert property (
    (q.mode && !enNSync && $rose(groupIn[`DXI_REQ_GROUP*`DXI_GROUP_W+`DXI_REQ_BIT])
     && q.edgeSel == `DXI_EDGE_RISE && !q.status[`DXI_ST_PEND] && !wrStb)
    ##1 (!enNSync && !wrStb && !q.status[`DXI_ST_PEND])
    ##1 (!enNSync && !q.status[`DXI_ST_PEND])
    |=> q.status[`DXI_ST_PEND])
    else $error("request latency wrong");

  // an accepted falling edge records the fall flag
  a_fall_sets_flag: assert property (
    (accept && reqFall) |=> (q.status[`DXI_ST_PEND] && q.status[`DXI_ST_FALL]))
    else $error("accepted falling edge not recorded");

  // rise flag only ever comes from a detected rising edge
  a_rise_from_edge: assert property (
    (!reqRise && !q.status[`DXI_ST_RISE]) |=> !q.status[`DXI_ST_RISE])
    else $error("rise flag set without a rising edge");

  // missed flag needs a pending interrupt to exist
  a_miss_needs_pend: assert property (
    (!q.status[`DXI_ST_PEND] && !q.status[`DXI_ST_MISS]) |=> !q.status[`DXI_ST_MISS])
    else $error("missed set with nothing pending");

  // read data stand only in the cycle after a read strobe
  a_rd_idle_zero: assert property (
    !rdStb |=> (rdData == '0))
    else $error("read data outside the answer cycle");

  // software clear removes the pending flag unless set again
  a_sw_clear: assert property (
    (clrPend && !accept) |=> !q.status[`DXI_ST_PEND])
    else $error("pending not cleared");

  // accepted edge latches group 0 when its latch is enabled
  a_latch_data: assert property (
    (accept && q.latchEn[0]) |=> (q.latch[0] == $past(groupIn[`DXI_GROUP_W-1:0])))
    else $error("group data not latched");

  // rising default after reset
  a_edge_default: assert property (
    ($rose(resetn) || !$past(wrStb)) && $past(q.edgeSel) == `DXI_EDGE_RISE
    |-> q.edgeSel == `DXI_EDGE_RISE)
    else $error("edge selection left rising default");

  // main scenarios
  c_rise_irq:  cover property (accept && reqRise ##1 irqOut);
  c_both_two:  cover property (accept && reqRise ##[1:50] accept && reqFall);
  c_missed:    cover property (ignored && !q.missSeen);
  c_latched:   cover property (accept && |q.latchEn);
  c_fall_only: cover property (accept && reqFall && q.edgeSel == `DXI_EDGE_FALL);

endmodule // dxi_ext_irq

// ==== dxi_defines.svh ====
// Purpose: constants of the external interrupt block (offsets, fields, codes)
// Assumes: byte addresses on a plain register port, 32-bit data
// Notes:   included by the package, by dxi_ext_irq and by the bench
`ifndef DXI_DEFINES_SVH
`define DXI_DEFINES_SVH

// geometry of the port groups
`define DXI_GROUPS      4
`define DXI_GROUP_W     24
`define DXI_ADDR_W      8
`define DXI_DATA_W      32
// position of the two reassignable lines inside group 3 (port C bits 7 and 6)
`define DXI_ENN_BIT     23
`define DXI_REQ_BIT     22
`define DXI_REQ_GROUP   3

// register offsets
`define DXI_OFF_CTRL    8'h00
`define DXI_OFF_STATUS  8'h04
`define DXI_OFF_CLEAR   8'h08
`define DXI_OFF_IRQEN   8'h0C
`define DXI_OFF_LATCH0  8'h10
`define DXI_OFF_LATCH3  8'h1C

// control register fields
`define DXI_CTRL_MODE   0
`define DXI_CTRL_EDGE   1
`define DXI_CTRL_LATCH  4

// edge selection codes
`define DXI_EDGE_RISE   2'h0
`define DXI_EDGE_FALL   2'h1
`define DXI_EDGE_BOTH   2'h2

// status, clear and enable bit positions
`define DXI_ST_PEND     0
`define DXI_ST_MISS     1
`define DXI_ST_RISE     2
`define DXI_ST_FALL     3
`define DXI_ST_W        4

`endif

// ==== dxi_pkg.sv ====
// Purpose: types of the external interrupt block
// Assumes: constants come from the defines header
// Notes:   one packed struct per module holds all its state
`include "dxi_defines.svh"
package dxi_pkg;

  // state of the synchroniser and edge detector
  typedef struct packed {
    logic reqMeta;  // first stage, request
    logic reqSync;  // second stage, request
    logic reqPrev;  // delayed copy for edge detect
    logic enMeta;   // first stage, enable
    logic enSync;   // second stage, enable
  } dxi_sync_t;

  // state of the top block
  typedef struct packed {
    logic                                       mode;     // pins used for interrupt
    logic [1:0]                                 edgeSel;  // trigger edge selection
    logic [`DXI_GROUPS-1:0]                     latchEn;  // per-group latch option
    logic [`DXI_ST_W-1:0]                       status;   // sticky flags
    logic [`DXI_ST_W-1:0]                       irqEn;    // interrupt enables
    logic                                       missSeen; // miss already recorded
    logic [`DXI_GROUPS-1:0][`DXI_GROUP_W-1:0]   latch;    // latched input data
    logic [`DXI_DATA_W-1:0]                     rdData;   // read answer
    logic                                       irq;      // interrupt output
  } dxi_state_t;

endpackage

// ==== dxi_sync_edge.sv ====
// Purpose: synchronise request and enable pins, detect request edges
// Assumes: single clock, asynchronous active-low reset
// Notes:   edge pulses are one cycle, two cycles after the pin change
`timescale 1ns/100ps
module dxi_sync_edge
  import dxi_pkg::*;
(
  input  wire logic clk,      // board clock
  input  wire logic resetn,   // async reset, active low
  input  wire logic reqIn,    // raw request pin
  input  wire logic enNIn,    // raw enable pin, active low
  output logic      reqRise,  // one-cycle pulse on rising edge
  output logic      reqFall,  // one-cycle pulse on falling edge
  output logic      enNSync   // synchronised enable, active low
);

  dxi_sync_t q;  // registered state
  dxi_sync_t d;  // next state

  // shift the two stages; first stage feeds only the second
  always_comb begin
    d         = q;
    d.reqMeta = reqIn;
    d.reqSync = q.reqMeta;
    d.reqPrev = q.reqSync;
    d.enMeta  = enNIn;
    d.enSync  = q.enMeta;
  end

  // reset to idle high enable (disabled) and low request
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= '{reqMeta: 1'b0, reqSync: 1'b0, reqPrev: 1'b0, enMeta: 1'b1, enSync: 1'b1};
    end else begin
      q <= d;
    end
  end

  // edges from the synchronised stage only
  assign reqRise = q.reqSync & ~q.reqPrev;
  assign reqFall = ~q.reqSync & q.reqPrev;
  assign enNSync = q.enSync;

endmodule // dxi_sync_edge

// ==== dxi_ext_partner.sv ====
// Purpose: external circuit model that drives the request and enable pins
// Assumes: pins change just after a rising clock edge
// Notes:   both pins are always driven, so no pull-up level is modelled
`timescale 1ns/100ps
module dxi_ext_partner (
  input  wire logic clk,     // board clock
  output logic      reqPin,  // request line, edge carries meaning
  output logic      enNPin   // enable line, active low
);
  // idle state: request low, requests blocked
  initial begin
    reqPin = 1'b0;
    enNPin = 1'b1;
  end

  // permit or block requests at the device
  task automatic permit(input logic on);
    @(posedge clk);
    enNPin <= ~on;
  endtask

  // move the request line and hold it, long enough to be seen once
  task automatic level(input logic v, input int n);
    @(posedge clk);
    reqPin <= v;
    repeat (n) @(posedge clk);
  endtask
endmodule // dxi_ext_partner

// ==== dxi_ext_irq_tb_top.sv ====
// Purpose: self-checking bench of the external interrupt block
// Assumes: register map as set in the defines header
// Notes:   the partner model owns the request and enable pins
`timescale 1ns/100ps
`include "dxi_defines.svh"
module dxi_ext_irq_tb_top
  import dxi_pkg::*;
();
  logic        clk;         // 10 MHz clock
  logic        resetn;      // async reset, active low
  logic [7:0]  addr;        // register address
  logic [31:0] wrData;      // write data
  logic        wrStb;       // write strobe
  logic        rdStb;       // read strobe
  logic [93:0] groupData;   // plain input lines of all groups
  logic        reqPin;      // request pin from partner
  logic        enNPin;      // enable pin from partner, active low
  logic [31:0] rdData;      // read answer
  logic        irqOut;      // interrupt level
  int          fail_count;  // mismatches
  int          compares;    // comparisons made
  wire  [95:0] groupIn = {enNPin, reqPin, groupData};

  dxi_ext_irq DUT (.clk(clk), .resetn(resetn), .addr(addr), .wrData(wrData), .wrStb(wrStb),
    .rdStb(rdStb), .groupIn(groupIn), .rdData(rdData), .irqOut(irqOut));
  dxi_ext_partner P (.clk(clk), .reqPin(reqPin), .enNPin(enNPin));

  // free-running clock, 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // one comparison, counted, reported at once
  task automatic chk(input string n, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", n, exp, got);
    end
  endtask

  // single-cycle register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr   <= a;
    wrData <= d;
    wrStb  <= 1'b1;
    @(posedge clk);
    wrStb  <= 1'b0;
  endtask

  // single-cycle read, data checked in the following cycle only
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string n);
    @(posedge clk);
    addr  <= a;
    rdStb <= 1'b1;
    @(posedge clk);
    rdStb <= 1'b0;
    #1 chk(n, exp, rdData);
  endtask

  // counts, verdict and end of run
  task automatic results();
    $display("comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // watchdog, far beyond the expected run of a few hundred cycles
  initial begin
    #(3000 * 100);
    fail_count++;
    results();
  end

  // main sequence
  initial begin
    fail_count = 0;
    compares   = 0;
    resetn     = 1'b0;
    addr       = 8'h00;
    wrData     = 32'h0;
    wrStb      = 1'b0;
    rdStb      = 1'b0;
    groupData  = 94'h2A_5C3E_9716_0BD4_8F21_A6C3;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    // reset values and plain register access
    rd(`DXI_OFF_CTRL, 32'h0, "ctrl reset");
    rd(`DXI_OFF_STATUS, 32'h0, "status reset");
    rd(8'h20, 32'h0, "unmapped read");
    wr(`DXI_OFF_IRQEN, 32'h1);
    rd(`DXI_OFF_IRQEN, 32'h1, "irq enable");
    // pins left in port use: no request
    P.permit(1'b1);
    P.level(1'b1, 6);
    P.level(1'b0, 6);
    rd(`DXI_OFF_STATUS, 32'h0, "mode off");
    // interrupt use, enable pin high: no request
    wr(`DXI_OFF_CTRL, 32'h1);
    P.permit(1'b0);
    P.level(1'b1, 6);
    P.level(1'b0, 6);
    rd(`DXI_OFF_STATUS, 32'h0, "enable high");
    // accepted rising edge latches every group
    P.permit(1'b1);
    wr(`DXI_OFF_CTRL, 32'hF1);
    P.level(1'b1, 6);
    rd(`DXI_OFF_STATUS, 32'h5, "rising accepted");
    chk("irq raised", 32'h1, {31'h0, irqOut});
    for (int g = 0; g < 4; g++) begin
      rd(`DXI_OFF_LATCH0 + 8'(4 * g), {8'h0, groupIn[g*24 +: 24]}, "latch");
    end
    P.level(1'b0, 6);
    wr(`DXI_OFF_STATUS, 32'hF);
    wr(`DXI_OFF_CLEAR, 32'hF);
    repeat (2) @(posedge clk);
    chk("irq cleared", 32'h0, {31'h0, irqOut});
    rd(`DXI_OFF_STATUS, 32'h0, "status cleared");
    // every edge code, each half of a pulse checked alone
    for (int e = 0; e < 4; e++) begin
      wr(`DXI_OFF_CTRL, 32'h1 | 32'(e << 1));
      P.level(1'b1, 6);
      rd(`DXI_OFF_STATUS, (e != 1) ? 32'h5 : 32'h0, "rise half");
      wr(`DXI_OFF_CLEAR, 32'hF);
      P.level(1'b0, 6);
      rd(`DXI_OFF_STATUS, (e != 0) ? 32'h9 : 32'h0, "fall half");
      wr(`DXI_OFF_CLEAR, 32'hF);
    end
    // both edges with no service: fall is lost, missed set once
    wr(`DXI_OFF_CTRL, 32'h5);
    P.level(1'b1, 6);
    P.level(1'b0, 6);
    rd(`DXI_OFF_STATUS, 32'h7, "fall while pending");
    P.level(1'b1, 6);
    P.level(1'b0, 6);
    rd(`DXI_OFF_STATUS, 32'h7, "later misses");
    // masking of the interrupt output
    wr(`DXI_OFF_IRQEN, 32'h2);
    repeat (2) @(posedge clk);
    chk("irq on missed", 32'h1, {31'h0, irqOut});
    wr(`DXI_OFF_IRQEN, 32'h8);
    repeat (2) @(posedge clk);
    chk("irq masked", 32'h0, {31'h0, irqOut});
    wr(`DXI_OFF_CLEAR, 32'hF);
    rd(`DXI_OFF_STATUS, 32'h0, "final clear");
    results();
  end
endmodule // dxi_ext_irq_tb_top
